//--- hw/amp_seq_defines.svh
/*
  Constants of the amplifier power sequencing host: device register map,
  command values, wait times and the software register map.
  Assumes a 10 MHz clock; every wait is derived from its time in ns.
*/
`ifndef AMP_SEQ_DEFINES_SVH
`define AMP_SEQ_DEFINES_SVH

`define AMP_CLK_NS          100
`define AMP_CYC(ns)         (((ns) + `AMP_CLK_NS - 1) / `AMP_CLK_NS)

`define AMP_T_RST_LOW_NS    100000
`define AMP_T_RELEASE_NS    13500000
`define AMP_T_TRIM_NS       50000000
`define AMP_T_GUARD_NS      240000000
`define AMP_T_BASE_NS       1000000
`define AMP_T_PFAIL_NS      2000000
`define AMP_T_RST_HOLD_NS   2000
`define AMP_T_MS_NS         1000000
`define AMP_SCALE_NUM       13
`define AMP_SCALE_DEN       10

`define AMP_DEV_SHUTDOWN    8'h05
`define AMP_DEV_PWM_TIME    8'h1A
`define AMP_DEV_OSC_TRIM    8'h1B
`define AMP_SD_ENTER_VAL    8'h40
`define AMP_SD_EXIT_VAL     8'h00
`define AMP_TRIM_VAL        8'h00

`define AMP_REG_CTRL        12'h000
`define AMP_REG_STATUS      12'h004
`define AMP_REG_TIMES       12'h008
`define AMP_REG_DEVWR       12'h00C

`define AMP_CTRL_UP         0
`define AMP_CTRL_EXIT       1
`define AMP_CTRL_ENTER      2
`define AMP_CTRL_DOWN       3
`define AMP_STAT_ERR        31
`define AMP_STAT_TRIM       30
`define AMP_STAT_GUARD      29
`define AMP_STAT_BUSY       28
`define AMP_STAT_SUPPLY     27
`define AMP_TIMES_RESET     16'h0000

`endif

//--- hw/amp_seq_pkg.sv
/*
  Types of the amplifier power sequencing host.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package amp_seq_pkg;

  typedef logic [7:0] dev_byte_t;

  typedef enum logic [12:0] {
    S_OFF        = 13'h0001,
    S_RST_LOW    = 13'h0002,
    S_RST_REL    = 13'h0004,
    S_TRIM_WR    = 13'h0008,
    S_TRIM_WAIT  = 13'h0010,
    S_SHUTDOWN   = 13'h0020,
    S_EXIT_WR    = 13'h0040,
    S_EXIT_WAIT  = 13'h0080,
    S_NORMAL     = 13'h0100,
    S_ENTER_WR   = 13'h0200,
    S_ENTER_WAIT = 13'h0400,
    S_PFAIL_WAIT = 13'h0800,
    S_PD_RST     = 13'h1000
  } seq_state_e;

endpackage

//--- hw/amp_wait_timer.sv
/*
  Down counter for minimum waits; done is high while the count is zero.
  Assumes load is a one-cycle pulse from logic on the same clock.
*/
`timescale 1ns/1ps
module amp_wait_timer (
  input  wire logic        clock_i,
  input  wire logic        srst_i,
  input  wire logic        load_i,
  input  wire logic [31:0] count_i,
  output logic             done_o
);
  logic [31:0] cnt_q;
  logic [31:0] cnt_d;

  always_comb begin
    cnt_d = cnt_q;
    if (load_i) begin
      cnt_d = count_i;
    end else if (cnt_q != 32'h0000_0000) begin
      cnt_d = cnt_q - 32'h0000_0001;
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      cnt_q <= 32'h0000_0000;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign done_o = (cnt_q == 32'h0000_0000);
endmodule

//--- hw/amp_power_host.sv
/*
  Host-side power, trim and shutdown sequencer for a class-D amplifier.
  Drives the reset and power-down pins, issues device register writes
  through a write port served by an external serial master, and takes
  orders from software over APB. Supply and power-fail pins are async.
*/
`timescale 1ns/1ps
`include "amp_seq_defines.svh"
module amp_power_host #(
  parameter int unsigned P_RELEASE_CYC = `AMP_CYC(`AMP_T_RELEASE_NS),
  parameter int unsigned P_TRIM_CYC    = `AMP_CYC(`AMP_T_TRIM_NS),
  parameter int unsigned P_GUARD_CYC   = `AMP_CYC(`AMP_T_GUARD_NS),
  parameter int unsigned P_BASE_CYC    = `AMP_CYC(`AMP_T_BASE_NS),
  parameter int unsigned P_MS_CYC      = `AMP_CYC(`AMP_T_MS_NS),
  parameter int unsigned P_PFAIL_CYC   = `AMP_CYC(`AMP_T_PFAIL_NS),
  parameter logic [7:0]  P_MUTE_ADDR   = 8'h06,
  parameter logic [7:0]  P_VOL_FIRST   = 8'h07,
  parameter logic [7:0]  P_VOL_LAST    = 8'h0A
) (
  input  wire logic                  clock_i,
  input  wire logic                  srst_i,
  input  wire logic                  psel_i,
  input  wire logic                  penable_i,
  input  wire logic                  pwrite_i,
  input  wire logic [11:0]           paddr_i,
  input  wire logic [31:0]           pwdata_i,
  output logic      [31:0]           prdata_o,
  output logic                       pready_o,
  output logic                       pslverr_o,
  input  wire logic                  supply_good_i,
  input  wire logic                  power_fail_i,
  input  wire logic                  dev_ack_i,
  output logic                       dev_req_o,
  output amp_seq_pkg::dev_byte_t     dev_addr_o,
  output amp_seq_pkg::dev_byte_t     dev_data_o,
  output logic                       reset_n_o,
  output logic                       power_down_pin_n_o,
  output logic                       inputs_drive_o
);
  import amp_seq_pkg::*;

  localparam logic [31:0] RST_LOW_CYC = 32'(`AMP_CYC(`AMP_T_RST_LOW_NS));
  localparam logic [31:0] HOLD_CYC    = 32'(`AMP_CYC(`AMP_T_RST_HOLD_NS));

  function automatic logic [31:0] scaled_wait(input logic [31:0] base, input dev_byte_t t_ms);
    return base + 32'((32'(t_ms) * P_MS_CYC * `AMP_SCALE_NUM) / `AMP_SCALE_DEN);
  endfunction

  function automatic logic addr_ok(input logic [11:0] a);
    return a == `AMP_REG_CTRL || a == `AMP_REG_STATUS ||
           a == `AMP_REG_TIMES || a == `AMP_REG_DEVWR;
  endfunction

  // Pin synchronisers: value moves only when stages two and three agree
  logic [1:0] sy1_q, sy2_q, sy3_q, syf_q, syf_d;
  logic       supply_q, pfail_q;

  always_comb begin
    syf_d = syf_q;
    for (int i = 0; i < 2; i++) begin
      if (sy2_q[i] == sy3_q[i]) begin
        syf_d[i] = sy3_q[i];
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      sy1_q <= 2'h0;
      sy2_q <= 2'h0;
      sy3_q <= 2'h0;
      syf_q <= 2'h0;
    end else begin
      sy1_q <= {power_fail_i, supply_good_i};
      sy2_q <= sy1_q;
      sy3_q <= sy2_q;
      syf_q <= syf_d;
    end
  end

  assign supply_q = syf_q[0];
  assign pfail_q  = syf_q[1];

  // APB slave: one wait state, ready and data from flops
  logic        pready_q, pready_d, pslverr_q, pslverr_d;
  logic [31:0] prdata_q, prdata_d;
  logic [15:0] times_q, times_d;
  logic        err_q, err_d, err_set;
  logic        pt_pend_q, pt_pend_d, pt_take;
  dev_byte_t   pt_addr_q, pt_addr_d, pt_data_q, pt_data_d;
  logic        wr_en, cmd_up, cmd_exit, cmd_enter, cmd_down, cmd_any;
  logic        pt_wr, pt_legal;
  seq_state_e  state_q, state_d;
  logic        dev_req_q, dev_req_d, trim_seen_q, trim_seen_d;
  logic        pd_pend_q, pd_pend_d, g_done, g_load, tmr_done, tmr_load;
  logic [31:0] tmr_val;
  dev_byte_t   dev_addr_q, dev_addr_d, dev_data_q, dev_data_d;
  logic        reset_n_q, reset_n_d, pdn_q, pdn_d, drive_q, drive_d;

  assign wr_en = psel_i && penable_i && pready_q && pwrite_i && !pslverr_q;
  assign cmd_up    = wr_en && paddr_i == `AMP_REG_CTRL && pwdata_i[`AMP_CTRL_UP];
  assign cmd_exit  = wr_en && paddr_i == `AMP_REG_CTRL && pwdata_i[`AMP_CTRL_EXIT];
  assign cmd_enter = wr_en && paddr_i == `AMP_REG_CTRL && pwdata_i[`AMP_CTRL_ENTER];
  assign cmd_down  = wr_en && paddr_i == `AMP_REG_CTRL && pwdata_i[`AMP_CTRL_DOWN];
  assign cmd_any   = cmd_up || cmd_exit || cmd_enter || cmd_down;
  assign pt_wr     = wr_en && paddr_i == `AMP_REG_DEVWR;
  // Free reconfiguration only while shut down; normal run limits targets
  assign pt_legal  = !pt_pend_q && (state_q == S_SHUTDOWN ||
                     (state_q == S_NORMAL && (pwdata_i[15:8] == P_MUTE_ADDR ||
                      (pwdata_i[15:8] >= P_VOL_FIRST && pwdata_i[15:8] <= P_VOL_LAST))));

  always_comb begin
    pready_d  = 1'b0;
    pslverr_d = 1'b0;
    prdata_d  = prdata_q;
    times_d   = times_q;
    pt_pend_d = pt_pend_q && !pt_take;
    pt_addr_d = pt_addr_q;
    pt_data_d = pt_data_q;
    err_d     = err_q;
    if (psel_i && penable_i && !pready_q) begin
      pready_d  = 1'b1;
      pslverr_d = !addr_ok(paddr_i);
      unique case (paddr_i)
        `AMP_REG_STATUS: prdata_d = {err_q, trim_seen_q, g_done, dev_req_q || pt_pend_q,
                                     supply_q, 14'h0000, 13'(state_q)};
        `AMP_REG_TIMES:  prdata_d = {16'h0000, times_q};
        `AMP_REG_DEVWR:  prdata_d = {15'h0000, pt_pend_q, pt_addr_q, pt_data_q};
        default:         prdata_d = 32'h0000_0000;
      endcase
    end
    if (wr_en && paddr_i == `AMP_REG_TIMES) begin
      times_d = pwdata_i[15:0];
    end
    if (wr_en && paddr_i == `AMP_REG_STATUS && pwdata_i[`AMP_STAT_ERR]) begin
      err_d = 1'b0;
    end
    if (pt_wr && pt_legal) begin
      pt_pend_d = 1'b1;
      pt_addr_d = pwdata_i[15:8];
      pt_data_d = pwdata_i[7:0];
    end
    // A refusal in the clearing cycle still sets the flag
    if (err_set || (pt_wr && !pt_legal)) begin
      err_d = 1'b1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      times_q   <= `AMP_TIMES_RESET;
      err_q     <= 1'b0;
      pt_pend_q <= 1'b0;
      pt_addr_q <= 8'h00;
      pt_data_q <= 8'h00;
    end else begin
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q  <= prdata_d;
      times_q   <= times_d;
      err_q     <= err_d;
      pt_pend_q <= pt_pend_d;
      pt_addr_q <= pt_addr_d;
      pt_data_q <= pt_data_d;
    end
  end

  amp_wait_timer u_step (
    .clock_i (clock_i),
    .srst_i  (srst_i),
    .load_i  (tmr_load),
    .count_i (tmr_val),
    .done_o  (tmr_done)
  );

  // Guard from the first trim after supply up; later trims never reload it
  amp_wait_timer u_guard (
    .clock_i (clock_i),
    .srst_i  (srst_i),
    .load_i  (g_load),
    .count_i (scaled_wait(32'(P_GUARD_CYC), times_q[7:0])),
    .done_o  (g_done)
  );

  always_comb begin
    logic idle;
    idle        = !dev_req_q && !pt_pend_q;
    state_d     = state_q;
    dev_req_d   = dev_req_q && !dev_ack_i;
    dev_addr_d  = dev_addr_q;
    dev_data_d  = dev_data_q;
    trim_seen_d = trim_seen_q;
    pd_pend_d   = pd_pend_q;
    tmr_load    = 1'b0;
    tmr_val     = 32'h0000_0000;
    g_load      = 1'b0;
    err_set     = 1'b0;
    pt_take     = 1'b0;
    unique case (state_q)
      S_OFF: begin
        if (cmd_up && supply_q) begin
          state_d  = S_RST_LOW;
          tmr_load = 1'b1;
          tmr_val  = RST_LOW_CYC;
        end else begin
          err_set = cmd_any;
        end
      end
      S_RST_LOW: begin
        if (tmr_done) begin
          state_d  = S_RST_REL;
          tmr_load = 1'b1;
          tmr_val  = 32'(P_RELEASE_CYC);
        end
      end
      S_RST_REL: begin
        if (tmr_done) begin
          state_d    = S_TRIM_WR;
          dev_req_d  = 1'b1;
          dev_addr_d = `AMP_DEV_OSC_TRIM;
          dev_data_d = `AMP_TRIM_VAL;
        end
      end
      S_TRIM_WR: begin
        if (dev_ack_i) begin
          state_d     = S_TRIM_WAIT;
          tmr_load    = 1'b1;
          tmr_val     = 32'(P_TRIM_CYC);
          g_load      = !trim_seen_q;
          trim_seen_d = 1'b1;
        end
      end
      S_TRIM_WAIT: begin
        if (tmr_done) begin
          state_d = S_SHUTDOWN;
        end
      end
      S_SHUTDOWN, S_NORMAL: begin
        if (!dev_req_q && pt_pend_q) begin
          dev_req_d  = 1'b1;
          dev_addr_d = pt_addr_q;
          dev_data_d = pt_data_q;
          pt_take    = 1'b1;
          err_set    = cmd_any;
        end else if (cmd_exit && idle && g_done && state_q == S_SHUTDOWN) begin
          state_d    = S_EXIT_WR;
          dev_req_d  = 1'b1;
          dev_addr_d = `AMP_DEV_SHUTDOWN;
          dev_data_d = `AMP_SD_EXIT_VAL;
        end else if ((cmd_enter || cmd_down) && idle && g_done && state_q == S_NORMAL) begin
          state_d    = S_ENTER_WR;
          pd_pend_d  = cmd_down;
          dev_req_d  = 1'b1;
          dev_addr_d = `AMP_DEV_SHUTDOWN;
          dev_data_d = `AMP_SD_ENTER_VAL;
        end else if (cmd_down && idle && state_q == S_SHUTDOWN) begin
          state_d  = S_PD_RST;
          tmr_load = 1'b1;
          tmr_val  = HOLD_CYC;
        end else begin
          err_set = cmd_any;
        end
      end
      S_EXIT_WR, S_ENTER_WR: begin
        err_set = cmd_any;
        if (dev_ack_i) begin
          state_d  = state_q == S_EXIT_WR ? S_EXIT_WAIT : S_ENTER_WAIT;
          tmr_load = 1'b1;
          tmr_val  = state_q == S_EXIT_WR ? scaled_wait(32'(P_BASE_CYC), times_q[7:0])
                                          : scaled_wait(32'(P_BASE_CYC), times_q[15:8]);
        end
      end
      S_EXIT_WAIT: begin
        err_set = cmd_any;
        if (tmr_done) begin
          state_d = S_NORMAL;
        end
      end
      S_ENTER_WAIT: begin
        err_set = cmd_any;
        if (tmr_done) begin
          state_d   = pd_pend_q ? S_PD_RST : S_SHUTDOWN;
          pd_pend_d = 1'b0;
          tmr_load  = pd_pend_q;
          tmr_val   = HOLD_CYC;
        end
      end
      S_PFAIL_WAIT, S_PD_RST: begin
        err_set = cmd_any;
        if (tmr_done) begin
          state_d  = state_q == S_PFAIL_WAIT ? S_PD_RST : S_OFF;
          tmr_load = state_q == S_PFAIL_WAIT;
          tmr_val  = HOLD_CYC;
        end
      end
      default: state_d = S_OFF;
    endcase
    // Power loss skips the orderly shutdown; supply loss drops the pins, the write request and the trim flag
    if (!supply_q) begin
      state_d     = S_OFF;
      dev_req_d   = 1'b0;
      trim_seen_d = 1'b0;
      pd_pend_d   = 1'b0;
    end else if (pfail_q && !(state_q inside {S_OFF, S_PFAIL_WAIT, S_PD_RST})) begin
      state_d   = S_PFAIL_WAIT;
      dev_req_d = 1'b0;
      pd_pend_d = 1'b0;
      tmr_load  = 1'b1;
      tmr_val   = 32'(P_PFAIL_CYC);
    end
    reset_n_d = !(state_d inside {S_OFF, S_RST_LOW, S_PD_RST});
    pdn_d     = !(state_d inside {S_OFF, S_PFAIL_WAIT, S_PD_RST});
    drive_d   = state_d != S_OFF;
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      state_q     <= S_OFF;
      dev_req_q   <= 1'b0;
      dev_addr_q  <= 8'h00;
      dev_data_q  <= 8'h00;
      trim_seen_q <= 1'b0;
      pd_pend_q   <= 1'b0;
      reset_n_q   <= 1'b0;
      pdn_q       <= 1'b0;
      drive_q     <= 1'b0;
    end else begin
      state_q     <= state_d;
      dev_req_q   <= dev_req_d;
      dev_addr_q  <= dev_addr_d;
      dev_data_q  <= dev_data_d;
      trim_seen_q <= trim_seen_d;
      pd_pend_q   <= pd_pend_d;
      reset_n_q   <= reset_n_d;
      pdn_q       <= pdn_d;
      drive_q     <= drive_d;
    end
  end

  assign prdata_o           = prdata_q;
  assign pready_o           = pready_q;
  assign pslverr_o          = pslverr_q;
  assign dev_req_o          = dev_req_q;
  assign dev_addr_o         = dev_addr_q;
  assign dev_data_o         = dev_data_q;
  assign reset_n_o          = reset_n_q;
  assign power_down_pin_n_o = pdn_q;
  assign inputs_drive_o     = drive_q;

  // Checking helpers: saturating cycle counts of pin levels and of cycles since the trim write ack
  logic [31:0] rlo_cnt_q, rhi_cnt_q, plo_cnt_q, trm_cnt_q;
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      rlo_cnt_q <= 32'h0000_0000;
      rhi_cnt_q <= 32'h0000_0000;
      plo_cnt_q <= 32'h0000_0000;
      trm_cnt_q <= 32'h0000_0000;
    end else begin
      rlo_cnt_q <= reset_n_q ? 32'h0000_0000 : rlo_cnt_q + 32'(rlo_cnt_q != '1);
      rhi_cnt_q <= !reset_n_q ? 32'h0000_0000 : rhi_cnt_q + 32'(rhi_cnt_q != '1);
      plo_cnt_q <= pdn_q ? 32'h0000_0000 : plo_cnt_q + 32'(plo_cnt_q != '1);
      trm_cnt_q <= (state_q == S_TRIM_WR && dev_ack_i) ? 32'h0000_0000
                   : trm_cnt_q + 32'(trm_cnt_q != '1);
    end
  end

  property p_supply_off;
    @(posedge clock_i) disable iff (srst_i)
    !supply_q |=> !drive_q && !reset_n_q && !pdn_q;
  endproperty
  a_supply_off: assert property (p_supply_off) else $error("inputs driven without supply");
  property p_rst_low;
    @(posedge clock_i) disable iff (srst_i)
    $rose(reset_n_q) |-> rlo_cnt_q >= RST_LOW_CYC && pdn_q;
  endproperty
  a_rst_low: assert property (p_rst_low) else $error("reset released too early");
  property p_release;
    @(posedge clock_i) disable iff (srst_i)
    $rose(dev_req_q) |-> rhi_cnt_q >= 32'(P_RELEASE_CYC);
  endproperty
  a_release: assert property (p_release) else $error("write too soon after reset");
  property p_trim;
    @(posedge clock_i) disable iff (srst_i)
    $rose(dev_req_q) && dev_addr_q != `AMP_DEV_OSC_TRIM |-> trm_cnt_q >= 32'(P_TRIM_CYC);
  endproperty
  a_trim: assert property (p_trim) else $error("write inside trim wait");
  property p_guard;
    @(posedge clock_i) disable iff (srst_i)
    $rose(dev_req_q) && dev_addr_q == `AMP_DEV_SHUTDOWN |-> g_done;
  endproperty
  a_guard: assert property (p_guard) else $error("shutdown change inside guard");
  property p_enter;
    @(posedge clock_i) disable iff (srst_i)
    state_q == S_ENTER_WR |-> dev_addr_q == `AMP_DEV_SHUTDOWN && dev_data_q == `AMP_SD_ENTER_VAL;
  endproperty
  a_enter: assert property (p_enter) else $error("bad shutdown entry write");
  property p_exit_wait;
    @(posedge clock_i) disable iff (srst_i)
    state_q == S_EXIT_WR && dev_ack_i ##1 supply_q && !pfail_q |-> state_q == S_EXIT_WAIT [*8];
  endproperty
  a_exit_wait: assert property (p_exit_wait) else $error("exit wait cut short");
  property p_pfail;
    @(posedge clock_i) disable iff (srst_i)
    $fell(reset_n_q) && $past(!pdn_q) && supply_q |-> plo_cnt_q >= 32'(P_PFAIL_CYC);
  endproperty
  a_pfail: assert property (p_pfail) else $error("reset before power-down wait");
  property p_hold;
    @(posedge clock_i) disable iff (srst_i)
    $fell(drive_q) && $past(supply_q) |-> rlo_cnt_q >= HOLD_CYC;
  endproperty
  a_hold: assert property (p_hold) else $error("inputs dropped before reset hold");
  property p_no_wr_rst;
    @(posedge clock_i) disable iff (srst_i)
    !reset_n_q |-> !dev_req_q;
  endproperty
  a_no_wr_rst: assert property (p_no_wr_rst) else $error("write while reset low");

  c_normal: cover property (@(posedge clock_i) disable iff (srst_i) $rose(state_q == S_NORMAL));
  c_shut:   cover property (@(posedge clock_i) disable iff (srst_i)
                            state_q == S_ENTER_WAIT ##1 state_q == S_SHUTDOWN);
  c_pfail:  cover property (@(posedge clock_i) disable iff (srst_i)
                            state_q == S_PFAIL_WAIT ##1 state_q == S_PD_RST);
endmodule

//--- test/amp_dev_model.sv
/*
  Behavioural amplifier model: a register file written through the host's
  device write port, with trim and shutdown state.
  Assumes the write port handshake of the host and one shared clock.
*/
`timescale 1ns/1ps
`include "amp_seq_defines.svh"
module amp_dev_model #(
  parameter logic [7:0] P_SD_RESET = 8'h40
) (
  input  wire logic       clock_i,
  input  wire logic       srst_i,
  input  wire logic       dev_req_i,
  input  wire logic [7:0] dev_addr_i,
  input  wire logic [7:0] dev_data_i,
  input  wire logic       reset_n_i,
  input  wire logic       power_down_pin_n_i,
  output logic            dev_ack_o
);
  logic [7:0] mem_q [256];
  logic [2:0] cnt_q;
  logic       slow_q;
  logic       trimmed_q;
  logic       pwm_on;
  logic [7:0] pwm_time;
  // Start and stop times live in one register
  assign pwm_time = mem_q[`AMP_DEV_PWM_TIME];
  // Bit 6 of the shutdown register stops the output stage
  assign pwm_on = reset_n_i & power_down_pin_n_i & ~mem_q[`AMP_DEV_SHUTDOWN][6];
  // Alternate fast and slow answers so the host never relies on latency
  always_ff @(posedge clock_i) begin
    dev_ack_o <= 1'b0;
    if (srst_i || !reset_n_i) begin
      for (int i = 0; i < 256; i++) begin
        mem_q[i] <= 8'h00;
      end
      mem_q[`AMP_DEV_SHUTDOWN] <= P_SD_RESET;
      cnt_q <= 3'h0;
      trimmed_q <= 1'b0;
      if (srst_i) begin
        slow_q <= 1'b0;
      end
    end else if (dev_req_i && !dev_ack_o) begin
      cnt_q <= cnt_q + 3'h1;
      if (cnt_q == (slow_q ? 3'h6 : 3'h1)) begin
        dev_ack_o <= 1'b1;
        cnt_q <= 3'h0;
        slow_q <= ~slow_q;
        mem_q[dev_addr_i] <= dev_data_i;
        if (dev_addr_i == `AMP_DEV_OSC_TRIM && dev_data_i == `AMP_TRIM_VAL) begin
          trimmed_q <= 1'b1;
        end
      end
    end
  end
endmodule

//--- test/amp_power_shutdown_sequencer_bench.sv
/*
  Bench of the amplifier power host: APB tasks give orders, the device
  model answers writes, pin edges are time-stamped in clock cycles.
  Assumes shortened wait parameters; expectations derive from them.
*/
`timescale 1ns/1ps
`include "amp_seq_defines.svh"
module amp_power_shutdown_sequencer_bench;
  import amp_seq_pkg::*;
  localparam int MS = 10;
  localparam int G  = 200 + 13 * 2 * MS / 10;
  localparam int XW = 30 + 13 * 2 * MS / 10;
  localparam int EW = 30 + 13 * 3 * MS / 10;
  localparam logic [31:0] ST = 32'h0000_1FFF;
  localparam logic [31:0] BZ = 32'h1000_0000;
  logic        clock, srst, psel, penable, pwrite, supply_good, power_fail;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, serr, dev_ack, dev_req, reset_n, power_down_pin_n;
  logic        inputs_drive, rst_p, pdn_p, req_p, drv_p;
  dev_byte_t   dev_addr, dev_data;
  int n_errors = 0, checks = 0, cyc = 0, t_ack = 0, t_trim = 0;
  int t_pdn = 0, t_rst = 0, t_rel = 0, t_req = 0, t_drv = 0;
  amp_power_host #(.P_RELEASE_CYC(50), .P_TRIM_CYC(60), .P_GUARD_CYC(200),
    .P_BASE_CYC(30), .P_MS_CYC(MS), .P_PFAIL_CYC(40)) amp_power_host_inst (
    .clock_i(clock), .srst_i(srst), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .supply_good_i(supply_good),
    .power_fail_i(power_fail), .dev_ack_i(dev_ack), .dev_req_o(dev_req),
    .dev_addr_o(dev_addr), .dev_data_o(dev_data), .reset_n_o(reset_n),
    .power_down_pin_n_o(power_down_pin_n), .inputs_drive_o(inputs_drive));
  amp_dev_model amp_dev_model_inst (.clock_i(clock), .srst_i(srst),
    .dev_req_i(dev_req), .dev_addr_i(dev_addr), .dev_data_i(dev_data),
    .reset_n_i(reset_n), .power_down_pin_n_i(power_down_pin_n), .dev_ack_o(dev_ack));
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  // Stamps use values sampled at the edge, so differences are exact cycles
  always @(posedge clock) begin
    cyc <= cyc + 1;
    rst_p <= reset_n;
    pdn_p <= power_down_pin_n;
    req_p <= dev_req;
    drv_p <= inputs_drive;
    if (dev_ack === 1'b1) t_ack <= cyc;
    if (pdn_p !== power_down_pin_n) t_pdn <= cyc;
    if (rst_p === 1'b1 && reset_n === 1'b0) t_rst <= cyc;
    if (rst_p === 1'b0 && reset_n === 1'b1) t_rel <= cyc;
    if (req_p === 1'b0 && dev_req === 1'b1) t_req <= cyc;
    if (drv_p === 1'b1 && inputs_drive === 1'b0) t_drv <= cyc;
  end
  task give_verdict;
    $display("checks %0d, errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task fail_to;
    n_errors++;
    $display("ERROR %0t wait ran out", $time);
    give_verdict();
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task chk_ge(input int got, input int min);
    checks++;
    if (got < min) begin
      n_errors++;
      $display("ERROR %0t wait %0d below %0d", $time, got, min);
    end
  endtask
  // Idle cycle first so a strobe is never assigned twice in one step
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    k = 0;
    // Looked at on the rising edge: answer and request both still stand
    do begin
      @(posedge clock);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) fail_to();
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task poll(input logic [31:0] mask, input logic [31:0] exp);
    int k;
    k = 0;
    do begin
      apb(1'b0, `AMP_REG_STATUS, 32'h0);
      k++;
    end while ((rd & mask) !== exp && k < 400);
    if (k >= 400) fail_to();
  endtask
  task clr_err;
    apb(1'b1, `AMP_REG_STATUS, 32'h8000_0000);
  endtask
  initial begin
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    supply_good = 1'b0;
    power_fail = 1'b0;
    repeat (4) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    chk({reset_n, power_down_pin_n, inputs_drive, dev_req}, 32'h0);
    apb(1'b0, 12'h0FC, 32'h0);
    chk(serr, 1'b1);
    apb(1'b1, `AMP_REG_CTRL, 32'h1);
    apb(1'b0, `AMP_REG_STATUS, 32'h0);
    chk(rd, 32'hA000_0001);
    clr_err();
    $display("test reset done");
    supply_good <= 1'b1;
    apb(1'b1, `AMP_REG_TIMES, 32'h0302);
    poll(32'h0800_0000, 32'h0800_0000);
    apb(1'b1, `AMP_REG_CTRL, 32'h1);
    poll(ST, 32'h0020);
    t_trim = t_ack;
    chk_ge(cyc - t_trim, 60);
    chk_ge(t_rel - t_pdn, 1000);
    chk_ge(t_req - t_rel, 50);
    chk(amp_dev_model_inst.trimmed_q, 1'b1);
    apb(1'b1, `AMP_REG_CTRL, 32'h2);
    apb(1'b0, `AMP_REG_STATUS, 32'h0);
    chk(rd[31:29], 3'b110);
    clr_err();
    apb(1'b1, `AMP_REG_DEVWR, 32'h1A23);
    poll(BZ, 32'h0);
    chk(amp_dev_model_inst.pwm_time, 8'h23);
    poll(32'h2000_0000, 32'h2000_0000);
    chk_ge(cyc - t_trim, G);
    $display("test power-up done");
    apb(1'b1, `AMP_REG_CTRL, 32'h2);
    poll(ST, 32'h0100);
    chk_ge(cyc - t_ack, XW);
    chk(amp_dev_model_inst.pwm_on, 1'b1);
    apb(1'b1, `AMP_REG_DEVWR, 32'h1A55);
    apb(1'b0, `AMP_REG_STATUS, 32'h0);
    chk(rd[31], 1'b1);
    clr_err();
    apb(1'b1, `AMP_REG_DEVWR, 32'h0730);
    poll(BZ, 32'h0);
    chk(amp_dev_model_inst.mem_q[8'h07], 8'h30);
    chk(amp_dev_model_inst.pwm_time, 8'h23);
    apb(1'b1, `AMP_REG_CTRL, 32'h4);
    poll(ST, 32'h0020);
    chk_ge(cyc - t_ack, EW);
    chk(amp_dev_model_inst.mem_q[`AMP_DEV_SHUTDOWN], `AMP_SD_ENTER_VAL);
    chk(amp_dev_model_inst.pwm_on, 1'b0);
    $display("test shutdown done");
    power_fail <= 1'b1;
    poll(ST, 32'h0001);
    chk_ge(t_rst - t_pdn, 40);
    chk_ge(t_drv - t_rst, 20);
    power_fail <= 1'b0;
    repeat (4) @(posedge clock);
    apb(1'b1, `AMP_REG_CTRL, 32'h1);
    poll(ST, 32'h0020);
    apb(1'b1, `AMP_REG_CTRL, 32'h2);
    apb(1'b0, `AMP_REG_STATUS, 32'h0);
    chk(rd[31], 1'b0);
    poll(ST, 32'h0100);
    apb(1'b1, `AMP_REG_CTRL, 32'h8);
    poll(ST, 32'h0001);
    chk_ge(t_rst - t_ack, EW);
    chk_ge(t_drv - t_rst, 20);
    $display("test power-down done");
    supply_good <= 1'b0;
    poll(32'h4800_1FFF, 32'h0000_0001);
    chk(inputs_drive, 1'b0);
    $display("test supply loss done");
    give_verdict();
  end
endmodule
